// >>> bench/mie_xmem_model.sv
// Behavioural far side of the external memory bus: wait-state source
`timescale 1ns/1ps
module mie_xmem_model
  import mie_pkg::*;
(
  input  wire logic              i_clk,      // System clock
  input  wire logic              i_rst_n,    // Reset, active low
  input  wire logic [WAIT_W-1:0] i_cfg_wait, // Wait states to program
  input  wire logic              i_busy,     // Core move in progress
  output logic      [WAIT_W-1:0] o_wait_n    // Wait-state count to the core
);
  // ------------------------------------------------------------
  // Wait-state count
  // ------------------------------------------------------------
  // count held steady
  // Held while a move runs so a move never sees the count change mid-flight
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !i_busy) begin
      o_wait_n <= i_cfg_wait;
    end
  end
endmodule

// >>> bench/move_instruction_execution_bench.sv
// Self-checking bench for the data-move instruction executor
`timescale 1ns/1ps
module move_instruction_execution_bench;
  import mie_pkg::*;
  logic               clk, rst_n, ce, src_mode, issue, ext, xwe, mode_exp, busy, done, smode_o;
  mie_form_e          form;
  logic [WAIT_W-1:0]  wait_n, cfg_wait;
  logic [1:0]         ka, kb;
  logic [15:0]        imm, wreg, data_pointer_16, maddr;
  logic [7:0]         bsrc, xwr, acc, xlow;
  logic [31:0]        dsrc, dreg;
  logic [STATE_W-1:0] states;
  logic [2:0]         nbytes;
  logic [23:0]        xaddr;
  int                 errors, n_tests, cyc;
  // Bytes and base states per form, binary then source encoding
  int bb[20] = '{5, 3, 3, 1, 1, 1, 1, 1, 1, 1, 2, 3, 3, 3, 3, 5, 4, 5, 5, 3};
  int sb[20] = '{4, 2, 2, 1, 1, 1, 1, 1, 1, 2, 2, 3, 2, 2, 2, 4, 3, 4, 4, 3};
  int bs[20] = '{3, 2, 2, 6, 6, 4, 3, 4, 4, 2, 1, 3, 2, 2, 3, 5, 6, 7, 6, 2};
  int ss[20] = '{2, 1, 1, 6, 6, 5, 3, 4, 4, 3, 1, 3, 1, 1, 2, 4, 5, 6, 5, 2};

  mie_move_exec mie_move_exec_inst (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CE(ce), .I_SRC_MODE(src_mode), .I_ISSUE(issue),
    .I_FORM(form), .I_EXT(ext), .I_WAIT_N(wait_n), .I_DIR_KIND_A(ka), .I_DIR_KIND_B(kb),
    .I_IMM16(imm), .I_BYTE_SRC(bsrc), .I_DWORD_SRC(dsrc), .I_XPTR_LOW_WR(xwr),
    .I_XPTR_LOW_WE(xwe), .O_BUSY(busy), .O_DONE(done), .O_STATES(states), .O_BYTES(nbytes),
    .O_SRC_MODE(smode_o), .O_ACCUMULATOR(acc), .O_WORD_REGISTER(wreg),
    .O_DWORD_REGISTER(dreg), .O_DATA_POINTER(data_pointer_16), .O_XPTR_LOW(xlow), .O_MEM_ADDR(maddr),
    .O_XMEM_ADDR(xaddr));

  mie_xmem_model mie_xmem_model_inst (
    .i_clk(clk), .i_rst_n(rst_n), .i_cfg_wait(cfg_wait), .i_busy(busy), .o_wait_n(wait_n));

  // ------------------------------------------------------------
  // Clock, timeout and reporting
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("ERROR t=%0t run did not finish", $time);
      final_report();
    end
  end

  task automatic final_report();
    $display("Summary: %0d comparisons, %0d mismatches", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Expected total states; a direct operand kind equals its penalty (0 RAM, 1 port, 2 periph)
  function automatic int exp_states(int f, logic e, int a, int b);
    int t;
    t = mode_exp ? ss[f] : bs[f];
    if (e) begin
      case (mie_form_e'(f))
        MF_CODE_READ_DATA_POINTER_16, MF_CODE_READ_PC, MF_XMEM_WR_DATA_POINTER_16: t += cfg_wait + 1;
        MF_XMEM_RD_DATA_POINTER_16, MF_BYTE_LOAD_DISP:                  t += cfg_wait + 2;
        MF_DWORD_TO_DIRECT_ADDRESS_16:                                   t += 4 * (cfg_wait + 2);
        default: ;
      endcase
    end
    if (f == 10 || f == 11 || f == 16) t += a;
    if (f == 11) t += b;
    return t;
  endfunction

  // Entered at a falling edge; returns at the falling edge of the done cycle
  task automatic run_move(input mie_form_e f, input logic e, input logic [1:0] a, b);
    int t;
    int cnt;
    form  = f;
    ext   = e;
    ka    = a;
    kb    = b;
    issue = 1'b1;
    @(negedge clk);
    issue = 1'b0;
    t     = exp_states(int'(f), e, int'(a), int'(b));
    check(states, t, "state count");
    check(nbytes, mode_exp ? sb[f] : bb[f], "byte length");
    cnt = 1;
    while (done !== 1'b1 && cnt < 80) begin
      @(negedge clk);
      cnt++;
    end
    check(cnt, t, "done timing");
  endtask

  task automatic do_reset(input logic m, input logic [WAIT_W-1:0] n);
    @(negedge clk);
    rst_n    = 1'b0;
    src_mode = m;
    mode_exp = m;
    cfg_wait = n;
    repeat (12) @(negedge clk);
    check(xlow, 8'h01, "pointer low byte in reset");
    check({busy, done, acc}, 10'h000, "idle in reset");
    rst_n = 1'b1;
    @(negedge clk);
    src_mode = ~m;
    @(negedge clk);
    check(smode_o, m, "latched encoding mode");
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_forms();
    for (int i = 0; i < 20; i++) run_move(mie_form_e'(i), 1'b0, 2'h0, 2'h0);
    for (int i = 0; i < 20; i++) run_move(mie_form_e'(i), 1'b1, 2'h0, 2'h0);
    $display("test forms done, mode %0d", mode_exp);
  endtask

  task automatic t_penalty();
    for (int a = 0; a < 3; a++) begin
      run_move(MF_ACC_FROM_DIRECT_ADDRESS_8, 1'b0, 2'(a), 2'h0);
      run_move(MF_DWORD_FROM_DIRECT_ADDRESS_8, 1'b0, 2'(a), 2'h0);
      for (int b = 0; b < 3; b++) run_move(MF_DIRECT_ADDRESS_8_TO_DIRECT_ADDRESS_8, 1'b0, 2'(a), 2'(b));
    end
    $display("test penalties done");
  endtask

  task automatic t_data();
    dsrc = 32'h1234_5678;
    run_move(MF_DWORD_REG_REG, 1'b0, 2'h0, 2'h0);
    check(dreg, 32'h1234_5678, "dword register move");
    imm = 16'habcd;
    run_move(MF_UPPER_WORD_LOAD, 1'b0, 2'h0, 2'h0);
    check(dreg, 32'habcd_5678, "upper word load");
    bsrc = 8'h9c;
    run_move(MF_SIGN_EXTEND_MOVE, 1'b0, 2'h0, 2'h0);
    check(wreg, 16'hff9c, "sign extend negative");
    run_move(MF_ZERO_EXTEND_MOVE, 1'b0, 2'h0, 2'h0);
    check(wreg, 16'h009c, "zero extend");
    bsrc = 8'h5a;
    run_move(MF_SIGN_EXTEND_MOVE, 1'b0, 2'h0, 2'h0);
    check(wreg, 16'h005a, "sign extend positive");
    imm  = 16'h8001;
    dsrc = 32'h0000_0000;
    run_move(MF_DWORD_EXT_IMM, 1'b0, 2'h0, 2'h0);
    check(dreg, 32'h0000_8001, "zero-extended immediate");
    dsrc = 32'h0000_0001;
    run_move(MF_DWORD_EXT_IMM, 1'b0, 2'h0, 2'h0);
    check(dreg, 32'hffff_8001, "one-extended immediate");
    $display("test data moves done");
  endtask

  task automatic t_code();
    bsrc = 8'h42;
    run_move(MF_ACC_FROM_IND, 1'b0, 2'h0, 2'h0);
    check(acc, 8'h42, "indirect accumulator load");
    bsrc = 8'h10;
    run_move(MF_ACC_FROM_DIRECT_ADDRESS_8, 1'b0, 2'h0, 2'h0);
    imm = 16'h2000;
    run_move(MF_DATA_POINTER_16_LOAD_IMM, 1'b0, 2'h0, 2'h0);
    check(data_pointer_16, 16'h2000, "data pointer load");
    bsrc = 8'h77;
    run_move(MF_CODE_READ_DATA_POINTER_16, 1'b0, 2'h0, 2'h0);
    check({maddr, acc}, 24'h2010_77, "code read via pointer");
    dsrc = 32'h0000_0100;
    bsrc = 8'h33;
    run_move(MF_CODE_READ_PC, 1'b0, 2'h0, 2'h0);
    check({maddr, acc}, 24'h0177_33, "code read via pc");
    $display("test code reads done");
  endtask

  task automatic t_xmem();
    imm = 16'h4321;
    run_move(MF_DATA_POINTER_16_LOAD_IMM, 1'b0, 2'h0, 2'h0);
    bsrc = 8'hc3;
    run_move(MF_XMEM_RD_DATA_POINTER_16, 1'b1, 2'h0, 2'h0);
    check(xaddr, 24'h01_4321, "extended read address");
    check(acc, 8'hc3, "extended read data");
    xwr = 8'h7e;
    xwe = 1'b1;
    @(negedge clk);
    xwe = 1'b0;
    check(xlow, 8'h7e, "pointer low byte write");
    run_move(MF_XMEM_WR_DATA_POINTER_16, 1'b0, 2'h0, 2'h0);
    check(xaddr, 24'h7e_4321, "extended write address");
    $display("test extended moves done");
  endtask

  task automatic t_refuse();
    int cnt;
    form  = MF_DWORD_TO_DIRECT_ADDRESS_16;
    ext   = 1'b1;
    issue = 1'b1;
    @(negedge clk);
    form = MF_DATA_POINTER_16_LOAD_IMM;
    imm  = 16'h5555;
    repeat (3) @(negedge clk);
    issue = 1'b0;
    cnt   = 4;
    while (done !== 1'b1 && cnt < 80) begin
      @(negedge clk);
      cnt++;
    end
    check(cnt, exp_states(17, 1'b1, 0, 0), "store under issue");
    @(negedge clk);
    check(data_pointer_16, 16'h4321, "issue while busy ignored");
    $display("test refusal done");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    errors = 0; n_tests = 0; cyc = 0; rst_n = 1'b0; ce = 1'b1; src_mode = 1'b0;
    issue = 1'b0; ext = 1'b0; xwe = 1'b0; mode_exp = 1'b0; form = MF_UPPER_WORD_LOAD;
    cfg_wait = '0; ka = 2'h0; kb = 2'h0; imm = 16'h0000; bsrc = 8'h00; xwr = 8'h00;
    dsrc = 32'h0000_0000;
    do_reset(1'b0, 3'h5);
    t_forms();
    t_penalty();
    t_data();
    t_code();
    t_xmem();
    t_refuse();
    do_reset(1'b1, 3'h7);
    t_forms();
    t_penalty();
    t_data();
    final_report();
  end
endmodule

// >>> pkg/mie_pkg.sv
// Constants and types for the data-move instruction decoder
// What this block does
// - Upper-word load writes bits 31..16; 3/2 states
// - Sign-extend byte into word; 2/1 states
// - Zero-extend byte into word; 2/1 states
// - Code read at acc plus pointer; 6 states
// - Extended region from pointer low byte, reset 01h
// - Byte-pointer extended read 4/5, write 4 states
// - Data-pointer extended read 3, write 4 states
// - External access adds wait-state dependent states, except byte-pointer moves
// - Port adds one state, peripheral adds two
// - Direct-to-direct base 3, penalty per operand
// - Legacy indirect accumulator load 2/1B, 3/2B
// - Register moves: dword 3/2, byte/word 2/1
// - Extended 16-bit immediate to dword 5/4 states
// - Dword from 8-bit direct 6/5 states
// - Dword store to 16-bit direct 7/6 plus
// - Byte load pointer plus displacement 6/5 states
// - Data pointer immediate load: 3 bytes, 2 states
package mie_pkg;

  // ------------------------------------------------------------
  // Move forms
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    MF_UPPER_WORD_LOAD,
    MF_SIGN_EXTEND_MOVE,
    MF_ZERO_EXTEND_MOVE,
    MF_CODE_READ_DATA_POINTER_16,
    MF_CODE_READ_PC,
    MF_XMEM_RD_RI,
    MF_XMEM_RD_DATA_POINTER_16,
    MF_XMEM_WR_RI,
    MF_XMEM_WR_DATA_POINTER_16,
    MF_ACC_FROM_IND,
    MF_ACC_FROM_DIRECT_ADDRESS_8,
    MF_DIRECT_ADDRESS_8_TO_DIRECT_ADDRESS_8,
    MF_BYTE_REG_REG,
    MF_WORD_REG_REG,
    MF_DWORD_REG_REG,
    MF_DWORD_EXT_IMM,
    MF_DWORD_FROM_DIRECT_ADDRESS_8,
    MF_DWORD_TO_DIRECT_ADDRESS_16,
    MF_BYTE_LOAD_DISP,
    MF_DATA_POINTER_16_LOAD_IMM
  } mie_form_e;

  // External access classes for the wait-state increment
  typedef enum logic [2:0] {
    XA_NONE,
    XA_N1,
    XA_N2,
    XA_WORD,
    XA_DWORD
  } mie_xacc_e;

  // Operand kinds of a direct address
  localparam logic [1:0] DIR_RAM    = 2'h0;
  localparam logic [1:0] DIR_PORT   = 2'h1;
  localparam logic [1:0] DIR_PERIPH = 2'h2;
  localparam logic [3:0] PEN_PORT   = 4'h1;
  localparam logic [3:0] PEN_PERIPH = 4'h2;

  // ------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------
  localparam int          STATE_W      = 6;
  localparam int          WAIT_W       = 3;
  localparam logic [7:0]  XPTR_LOW_RST = 8'h01;
  localparam logic [15:0] DATA_POINTER_16_RST     = 16'h0000;
  localparam logic [7:0]  ACC_RST      = 8'h00;
  localparam logic [31:0] DREG_RST     = 32'h0000_0000;
  localparam logic [15:0] WREG_RST     = 16'h0000;

  typedef logic [STATE_W-1:0] mie_cnt_t;

  // Result of the timing decoder
  typedef struct packed {
    logic [2:0] bytes;
    mie_cnt_t   base;
    mie_xacc_e  xacc;
  } mie_time_s;

endpackage

// >>> pkg/mie_tm_if.sv
// Interface between the executor and its timing decoder
`timescale 1ns/1ps
interface mie_tm_if;
  import mie_pkg::*;
  mie_form_e form;
  logic      src_mode;
  mie_time_s timing;
  modport exec (output form, output src_mode, input timing);
  modport dec  (input form, input src_mode, output timing);
endinterface

// >>> verilog/mie_move_exec.sv
// Data-move instruction executor with state-count sequencing
`timescale 1ns/1ps
module mie_move_exec
  import mie_pkg::*;
(
  input  wire logic              I_CLK_SYS,        // System clock, 20 MHz
  input  wire logic              I_RST_N,          // Asynchronous reset, active low
  input  wire logic              I_CE,             // Clock enable, freezes all state
  input  wire logic              I_SRC_MODE,       // Encoding: 1 source, 0 binary
  input  wire logic              I_ISSUE,          // Start one move, taken when idle
  input  wire mie_form_e         I_FORM,           // Move form to execute
  input  wire logic              I_EXT,            // Operand lies in external memory
  input  wire logic [WAIT_W-1:0] I_WAIT_N,         // Configured wait-state count
  input  wire logic [1:0]        I_DIR_KIND_A,     // Kind of first direct operand
  input  wire logic [1:0]        I_DIR_KIND_B,     // Kind of second direct operand
  input  wire logic [15:0]       I_IMM16,          // Immediate word
  input  wire logic [7:0]        I_BYTE_SRC,       // Byte register or memory byte
  input  wire logic [31:0]       I_DWORD_SRC,      // Doubleword source value
  input  wire logic [7:0]        I_XPTR_LOW_WR,    // New extended pointer low byte
  input  wire logic              I_XPTR_LOW_WE,    // Write strobe for that byte
  output logic                   O_BUSY,           // Move in progress
  output logic                   O_DONE,           // One-cycle pulse at move end
  output logic [STATE_W-1:0]     O_STATES,         // Total states of last move
  output logic [2:0]             O_BYTES,          // Instruction length in bytes
  output logic                   O_SRC_MODE,       // Latched encoding mode
  output logic [7:0]             O_ACCUMULATOR,    // Accumulator
  output logic [15:0]            O_WORD_REGISTER,  // Target word register
  output logic [31:0]            O_DWORD_REGISTER, // Target doubleword register
  output logic [15:0]            O_DATA_POINTER,   // 16-bit data pointer
  output logic [7:0]             O_XPTR_LOW,       // Extended region select
  output logic [15:0]            O_MEM_ADDR,       // Memory address of the access
  output logic [23:0]            O_XMEM_ADDR       // Extended-memory address
);

  // ------------------------------------------------------------
  // State and timing decoder
  // ------------------------------------------------------------
  typedef enum logic [0:0] {ST_IDLE, ST_RUN} mie_state_e;

  mie_state_e   state_reg;
  logic         mode_reg;
  logic         mode_set_reg;
  mie_cnt_t     cnt_reg;
  mie_form_e    form_reg;
  logic         busy_reg, done_reg;
  logic [5:0]   states_reg;
  logic [2:0]   bytes_reg;
  logic [7:0]   acc_reg;
  logic [15:0]  wreg_reg, data_pointer_16_reg, addr_reg;
  logic [31:0]  dreg_reg;
  logic [7:0]   xptr_reg;
  logic [23:0]  xaddr_reg;

  mie_tm_if tm ();
  assign tm.form     = I_FORM;
  assign tm.src_mode = mode_set_reg ? mode_reg : I_SRC_MODE;

  mie_timing_dec u_timing (
    .tm (tm)
  );

  // ------------------------------------------------------------
  // State-count arithmetic
  // ------------------------------------------------------------
  wire logic [5:0] wn      = {3'h0, I_WAIT_N};
  wire logic       take    = I_ISSUE && (state_reg == ST_IDLE);
  wire logic       is_dir  = (I_FORM == MF_ACC_FROM_DIRECT_ADDRESS_8) || (I_FORM == MF_DIRECT_ADDRESS_8_TO_DIRECT_ADDRESS_8)
                             || (I_FORM == MF_DWORD_FROM_DIRECT_ADDRESS_8);
  wire logic       two_dir = (I_FORM == MF_DIRECT_ADDRESS_8_TO_DIRECT_ADDRESS_8);
  wire logic [3:0] pen_a   = !is_dir ? 4'h0 : (I_DIR_KIND_A == DIR_PORT) ? PEN_PORT
                             : (I_DIR_KIND_A == DIR_PERIPH) ? PEN_PERIPH : 4'h0;
  wire logic [3:0] pen_b   = !two_dir ? 4'h0 : (I_DIR_KIND_B == DIR_PORT) ? PEN_PORT
                             : (I_DIR_KIND_B == DIR_PERIPH) ? PEN_PERIPH : 4'h0;
  logic [5:0] ext_add;
  always_comb begin
    ext_add = 6'h00;
    if (I_EXT) begin
      case (tm.timing.xacc)
        XA_N1:    ext_add = wn + 6'h01;
        XA_N2:    ext_add = wn + 6'h02;
        XA_WORD:  ext_add = 6'((wn + 6'h01) << 1);
        XA_DWORD: ext_add = 6'((wn + 6'h02) << 2);
        default:  ext_add = 6'h00;
      endcase
    end
  end
  wire logic [5:0] total = tm.timing.base + ext_add + {2'h0, pen_a} + {2'h0, pen_b};

  // ------------------------------------------------------------
  // Data results
  // ------------------------------------------------------------
  // region from pointer low byte
  wire logic [23:0] xaddr_ri   = {xptr_reg, 8'h00, I_BYTE_SRC};
  wire logic [23:0] xaddr_data_pointer_16 = {xptr_reg, data_pointer_16_reg};
  wire logic [15:0] code_addr  = (I_FORM == MF_CODE_READ_PC) ? I_DWORD_SRC[15:0]
                                 : data_pointer_16_reg;
  wire logic [15:0] code_sum   = code_addr + {8'h00, acc_reg};

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
    end else if (I_CE) begin
      done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: if (take) begin
          state_reg <= (total > 6'h01) ? ST_RUN : ST_IDLE;
          cnt_reg   <= total - 6'h01;
          busy_reg  <= (total > 6'h01);
          done_reg  <= (total <= 6'h01);
        end
        ST_RUN: begin
          cnt_reg <= cnt_reg - 6'h01;
          if (cnt_reg == 6'h01) begin
            state_reg <= ST_IDLE;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mode_reg     <= 1'b0;
      mode_set_reg <= 1'b0;
    end else if (I_CE && !mode_set_reg) begin
      mode_reg     <= I_SRC_MODE;
      mode_set_reg <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      form_reg   <= MF_BYTE_REG_REG;
      states_reg <= '0;
      bytes_reg  <= '0;
      addr_reg   <= '0;
      xaddr_reg  <= '0;
    end else if (I_CE && take) begin
      form_reg   <= I_FORM;
      states_reg <= total;
      bytes_reg  <= tm.timing.bytes;
      addr_reg   <= (I_FORM == MF_BYTE_LOAD_DISP) ? I_DWORD_SRC[15:0] + I_IMM16
                  : (I_FORM == MF_DWORD_TO_DIRECT_ADDRESS_16) ? I_IMM16 : code_sum;
      xaddr_reg  <= (I_FORM == MF_XMEM_RD_RI || I_FORM == MF_XMEM_WR_RI) ? xaddr_ri
                  : xaddr_data_pointer_16;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      xptr_reg <= XPTR_LOW_RST;
    end else if (I_CE && I_XPTR_LOW_WE) begin
      xptr_reg <= I_XPTR_LOW_WR;
    end
  end

  // Results are written when the move is taken
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      acc_reg  <= ACC_RST;
      wreg_reg <= WREG_RST;
      dreg_reg <= DREG_RST;
      data_pointer_16_reg <= DATA_POINTER_16_RST;
    end else if (I_CE && take) begin
      case (I_FORM)
        MF_UPPER_WORD_LOAD:  dreg_reg[31:16] <= I_IMM16;
        MF_SIGN_EXTEND_MOVE: wreg_reg <= {{8{I_BYTE_SRC[7]}}, I_BYTE_SRC};
        MF_ZERO_EXTEND_MOVE: wreg_reg <= {8'h00, I_BYTE_SRC};
        MF_CODE_READ_DATA_POINTER_16, MF_CODE_READ_PC, MF_XMEM_RD_RI, MF_XMEM_RD_DATA_POINTER_16,
        MF_ACC_FROM_IND, MF_ACC_FROM_DIRECT_ADDRESS_8, MF_BYTE_LOAD_DISP,
        MF_BYTE_REG_REG:     acc_reg <= I_BYTE_SRC;
        MF_WORD_REG_REG:     wreg_reg <= I_DWORD_SRC[15:0];
        MF_DWORD_REG_REG,
        MF_DWORD_FROM_DIRECT_ADDRESS_8:  dreg_reg <= I_DWORD_SRC;
        MF_DWORD_EXT_IMM:    dreg_reg <= {{16{I_DWORD_SRC[0]}}, I_IMM16};
        MF_DATA_POINTER_16_LOAD_IMM:    data_pointer_16_reg <= I_IMM16;
        default:             acc_reg <= acc_reg;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign O_BUSY           = busy_reg;
  assign O_DONE           = done_reg;
  assign O_STATES         = states_reg;
  assign O_BYTES          = bytes_reg;
  assign O_SRC_MODE       = mode_reg;
  assign O_ACCUMULATOR    = acc_reg;
  assign O_WORD_REGISTER  = wreg_reg;
  assign O_DWORD_REGISTER = dreg_reg;
  assign O_DATA_POINTER   = data_pointer_16_reg;
  assign O_XPTR_LOW       = xptr_reg;
  assign O_MEM_ADDR       = addr_reg;
  assign O_XMEM_ADDR      = xaddr_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_taken;
    I_CE && take;
  endsequence

  a_busy_count: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    O_BUSY && I_CE && cnt_reg == 6'h01 |=> O_DONE && !O_BUSY)
    else $error("move did not finish at count end");
  a_upper_word: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_taken ##0 (I_FORM == MF_UPPER_WORD_LOAD) |=> O_DWORD_REGISTER[15:0]
    == $past(dreg_reg[15:0]) && O_DWORD_REGISTER[31:16] == $past(I_IMM16))
    else $error("upper word load wrong");
  a_sign_ext: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_taken ##0 (I_FORM == MF_SIGN_EXTEND_MOVE) |=>
    O_WORD_REGISTER[15:8] == {8{O_WORD_REGISTER[7]}})
    else $error("sign extension wrong");
  a_zero_ext: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_taken ##0 (I_FORM == MF_ZERO_EXTEND_MOVE) |=> O_WORD_REGISTER[15:8] == 8'h00)
    else $error("zero extension wrong");
  a_code_read: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_taken ##0 (I_FORM == MF_CODE_READ_DATA_POINTER_16) && !I_EXT |=> O_STATES == 6'h06)
    else $error("code read state count wrong");
  a_data_pointer_16_xread: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_taken ##0 (I_FORM == MF_XMEM_RD_DATA_POINTER_16) |=>
    O_STATES == 6'h03 + ($past(I_EXT) ? $past(wn) + 6'h02 : 6'h00))
    else $error("extended read state count wrong");
  a_dir_pen: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_taken ##0 (I_FORM == MF_DIRECT_ADDRESS_8_TO_DIRECT_ADDRESS_8) && I_DIR_KIND_A == DIR_PERIPH
    && I_DIR_KIND_B == DIR_PORT |=> O_STATES == 6'h06)
    else $error("direct move penalty wrong");
  a_data_pointer_16_load: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_taken ##0 (I_FORM == MF_DATA_POINTER_16_LOAD_IMM) |=> O_STATES == 6'h02 && O_BYTES == 3'h3)
    else $error("pointer load timing wrong");

endmodule

// >>> verilog/mie_timing_dec.sv
// Byte length and base state count of each move form
`timescale 1ns/1ps
module mie_timing_dec
  import mie_pkg::*;
(
  mie_tm_if.dec tm  // Form in, timing out
);

  logic sm;
  assign sm = tm.src_mode;

  // ------------------------------------------------------------
  // Timing table
  // ------------------------------------------------------------
  // mode picks length and count
  always_comb begin
    tm.timing = '{bytes: 3'h1, base: 6'h01, xacc: XA_NONE};
    case (tm.form)
      MF_UPPER_WORD_LOAD: tm.timing = '{sm ? 3'h4 : 3'h5, sm ? 6'h02 : 6'h03, XA_NONE};
      MF_SIGN_EXTEND_MOVE: tm.timing = '{sm ? 3'h2 : 3'h3, sm ? 6'h01 : 6'h02, XA_NONE};
      MF_ZERO_EXTEND_MOVE: tm.timing = '{sm ? 3'h2 : 3'h3, sm ? 6'h01 : 6'h02, XA_NONE};
      MF_CODE_READ_DATA_POINTER_16,
      MF_CODE_READ_PC:    tm.timing = '{3'h1, 6'h06, XA_N1};
      MF_XMEM_RD_RI:      tm.timing = '{3'h1, sm ? 6'h05 : 6'h04, XA_NONE};
      MF_XMEM_WR_RI:      tm.timing = '{3'h1, 6'h04, XA_NONE};
      MF_XMEM_RD_DATA_POINTER_16:    tm.timing = '{3'h1, 6'h03, XA_N2};
      MF_XMEM_WR_DATA_POINTER_16:    tm.timing = '{3'h1, 6'h04, XA_N1};
      MF_ACC_FROM_IND:    tm.timing = '{sm ? 3'h2 : 3'h1, sm ? 6'h03 : 6'h02, XA_NONE};
      MF_ACC_FROM_DIRECT_ADDRESS_8:   tm.timing = '{3'h2, 6'h01, XA_NONE};
      MF_DIRECT_ADDRESS_8_TO_DIRECT_ADDRESS_8:    tm.timing = '{3'h3, 6'h03, XA_NONE};
      MF_BYTE_REG_REG,
      MF_WORD_REG_REG:    tm.timing = '{sm ? 3'h2 : 3'h3, sm ? 6'h01 : 6'h02, XA_NONE};
      MF_DWORD_REG_REG:   tm.timing = '{sm ? 3'h2 : 3'h3, sm ? 6'h02 : 6'h03, XA_NONE};
      MF_DWORD_EXT_IMM:   tm.timing = '{sm ? 3'h4 : 3'h5, sm ? 6'h04 : 6'h05, XA_NONE};
      MF_DWORD_FROM_DIRECT_ADDRESS_8: tm.timing = '{sm ? 3'h3 : 3'h4, sm ? 6'h05 : 6'h06, XA_NONE};
      MF_DWORD_TO_DIRECT_ADDRESS_16:  tm.timing = '{sm ? 3'h4 : 3'h5, sm ? 6'h06 : 6'h07, XA_DWORD};
      MF_BYTE_LOAD_DISP:  tm.timing = '{sm ? 3'h4 : 3'h5, sm ? 6'h05 : 6'h06, XA_N2};
      MF_DATA_POINTER_16_LOAD_IMM:   tm.timing = '{3'h3, 6'h02, XA_NONE};
      default:            tm.timing = '{3'h1, 6'h01, XA_NONE};
    endcase
  end

endmodule
